// File: i2c_slave_random_read.sv
// Purpose: slave read engine with sequential streaming from a pointer
// Assumes: memory answers within one core cycle of a stable address
// Notes:   write data bytes are handled elsewhere; this block only
//          acknowledges the write-direction instruction bytes
`timescale 1ns/1ps
module i2c_slave_random_read
    import i2c_rr_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    input  wire logic [DATA_W-1:0] MEM_RDATA_I,
    input  wire logic [DATA_W-1:0] WIPER_POSITION_REGISTER_I,
    input  wire logic [DATA_W-1:0] STORED_WIPER_VALUE_I,
    input  wire logic              VOLATILE_ONLY_SELECT_I,
    input  wire logic              NV_WRITE_PENDING_I,
    input  wire logic              NV_WRITE_BUSY_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_N_O,
    output logic [ADDR_W-1:0]      MEM_ADDR_O,
    output logic                   NV_WRITE_START_O,
    output logic                   READ_ACTIVE_O
);

    line_event_type    ev;
    state_type         state_reg,  state_next;
    byte_kind_type     kind_reg,   kind_next;
    logic [3:0]        cnt_reg,    cnt_next;
    logic [DATA_W-1:0] shift_reg,  shift_next;
    logic [ADDR_W-1:0] ptr_reg,    ptr_next;
    logic              oe_n_reg,   oe_n_next;
    logic              ack_reg,    ack_next;
    logic              nv_reg,     nv_next;
    logic              rd_reg,     rd_next;
    logic              load;
    logic [DATA_W-1:0] fetched;

    // byte source: wiper location is not memory
    function automatic logic [DATA_W-1:0] fetch_byte(
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] mem,
        input logic [DATA_W-1:0] live,
        input logic [DATA_W-1:0] stored,
        input logic              vol_only
    );
        if (addr != WIPER_ADDR)
            return mem;
        return vol_only ? live : stored;
    endfunction : fetch_byte

    function automatic logic id_valid(input logic [DATA_W-1:0] b);
        return b[DATA_W-1:ID_DEV_LSB] == DEV_SELECT;
    endfunction : id_valid

    i2c_line_watch u_watch (
        .clk_i (CORE_CLK_I),
        .rst_i (SYS_RST_I),
        .scl_i (SCL_I),
        .sda_i (SDA_I),
        .ev_o  (ev)
    );

    assign fetched = fetch_byte(ptr_reg, MEM_RDATA_I, WIPER_POSITION_REGISTER_I,
                                STORED_WIPER_VALUE_I, VOLATILE_ONLY_SELECT_I);

    // protocol engine; a stop, or a start outside a non-volatile cycle, overrides any byte in flight
    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        oe_n_next  = oe_n_reg;
        ack_next   = ack_reg;
        nv_next    = 1'b0;
        load       = 1'b0;
        if (ev.stop) begin
            state_next = ST_IDLE;
            oe_n_next  = 1'b1;
            nv_next    = NV_WRITE_PENDING_I;
        end else if (ev.start && !NV_WRITE_BUSY_I) begin
            // starts are ignored while a non-volatile cycle runs
            state_next = ST_RX;
            kind_next  = KIND_ID;
            cnt_next   = CNT_ZERO;
            oe_n_next  = 1'b1;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (ev.scl_rise) begin
                        shift_next = {shift_reg[DATA_W-2:0], ev.sda};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (ev.scl_fall && cnt_reg == BITS_LAST) begin
                        if (kind_reg == KIND_ADDR) begin
                            ptr_next[DATA_W-1:0] = shift_reg;
                            oe_n_next  = 1'b0;
                            state_next = ST_ACK_OUT;
                        end else if (id_valid(shift_reg)) begin
                            ptr_next[ADDR_W-1:DATA_W] = shift_reg[ID_HI_LSB +: HI_W];
                            kind_next  = shift_reg[ID_RW_BIT] ? KIND_READ : KIND_WRITE;
                            oe_n_next  = 1'b0;
                            state_next = ST_ACK_OUT;
                        end else begin
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_ACK_OUT: begin
                    if (ev.scl_fall) begin
                        oe_n_next = 1'b1;
                        cnt_next  = CNT_ZERO;
                        case (kind_reg)
                            KIND_WRITE: begin
                                kind_next  = KIND_ADDR;
                                state_next = ST_RX;
                            end
                            KIND_READ: load = 1'b1;
                            // write data is not taken here; wait for repeated start
                            default: state_next = ST_WAIT;
                        endcase
                    end
                end
                ST_TX: begin
                    if (ev.scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (cnt_reg == BITS_LAST) begin
                            oe_n_next  = 1'b1;         // master owns the ninth bit
                            cnt_next   = CNT_ZERO;
                            state_next = ST_ACK_IN;
                        end else begin
                            shift_next = {shift_reg[DATA_W-2:0], 1'b0};
                            oe_n_next  = shift_reg[DATA_W-2]; // open drain: high released
                        end
                    end
                end
                ST_ACK_IN: begin
                    if (ev.scl_rise) begin
                        ack_next = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        if (ack_reg)
                            load = 1'b1;
                        else
                            state_next = ST_WAIT;
                    end
                end
                ST_IDLE, ST_WAIT: ;
                default: state_next = ST_IDLE;
            endcase
        end
        if (load) begin
            shift_next = fetched;
            ptr_next   = ptr_reg + PTR_STEP;
            oe_n_next  = fetched[DATA_W-1];
            cnt_next   = CNT_ZERO;
            state_next = ST_TX;
        end
        rd_next = (state_next == ST_TX) || (state_next == ST_ACK_IN);
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_ID;
            cnt_reg   <= CNT_ZERO;
            shift_reg <= '0;
            ptr_reg   <= PTR_RESET;
            oe_n_reg  <= 1'b1;
            ack_reg   <= 1'b0;
            nv_reg    <= 1'b0;
            rd_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
            oe_n_reg  <= oe_n_next;
            ack_reg   <= ack_next;
            nv_reg    <= nv_next;
            rd_reg    <= rd_next;
        end
    end

    // the pin only ever pulls low; level comes from the enable
    always_ff @(posedge CORE_CLK_I) begin
        SDA_O <= 1'b0;
    end

    assign SDA_OE_N_O       = oe_n_reg;
    assign MEM_ADDR_O       = ptr_reg;
    assign NV_WRITE_START_O = nv_reg;
    assign READ_ACTIVE_O    = rd_reg;

    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic eval_cycle;
    assign eval_cycle = state_reg == ST_RX && ev.scl_fall && cnt_reg == BITS_LAST
                        && !ev.stop && !ev.start;

    property p_nv_only_stop;
        NV_WRITE_START_O |-> $past(ev.stop) && $past(NV_WRITE_PENDING_I);
    endproperty
    a_nv_only_stop: assert property (p_nv_only_stop) else $error("nv write without stop");

    property p_ack_id;
        eval_cycle && kind_reg == KIND_ID && id_valid(shift_reg)
            |=> !SDA_OE_N_O && state_reg == ST_ACK_OUT;
    endproperty
    a_ack_id: assert property (p_ack_id) else $error("valid id not acknowledged");

    property p_bad_id;
        eval_cycle && kind_reg == KIND_ID && !id_valid(shift_reg)
            |=> SDA_OE_N_O && state_reg == ST_WAIT;
    endproperty
    a_bad_id: assert property (p_bad_id) else $error("foreign id acknowledged");

    property p_addr_low;
        eval_cycle && kind_reg == KIND_ADDR |=> MEM_ADDR_O[DATA_W-1:0] == $past(shift_reg);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address byte not loaded");

    property p_continue;
        state_reg == ST_ACK_IN && ack_reg && ev.scl_fall && !ev.stop && !ev.start
            |=> state_reg == ST_TX && READ_ACTIVE_O;
    endproperty
    a_continue: assert property (p_continue) else $error("acked read did not continue");

    property p_step;
        load && !ev.stop |=> MEM_ADDR_O == $past(MEM_ADDR_O) + PTR_STEP && shift_reg == $past(fetched);
    endproperty
    a_step: assert property (p_step) else $error("pointer did not step by one");

    property p_nack_release;
        state_reg == ST_ACK_IN && !ack_reg && ev.scl_fall && !ev.start
            |=> SDA_OE_N_O [*2];
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("sda held after nack");

    property p_stop_idle;
        ev.stop |=> state_reg == ST_IDLE && SDA_OE_N_O ##1 !READ_ACTIVE_O;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not reach standby");

    property p_wiper;
        load && MEM_ADDR_O == WIPER_ADDR
            |=> shift_reg == ($past(VOLATILE_ONLY_SELECT_I) ? $past(WIPER_POSITION_REGISTER_I)
                                                             : $past(STORED_WIPER_VALUE_I));
    endproperty
    a_wiper: assert property (p_wiper) else $error("wrong wiper source");

    c_byte_sent: cover property (state_reg == ST_TX ##[1:600] state_reg == ST_ACK_IN);
    c_nack:      cover property (state_reg == ST_ACK_IN && !ack_reg && ev.scl_fall);
    c_nv_start:  cover property (NV_WRITE_START_O);
    c_wiper:     cover property (load && ptr_reg == WIPER_ADDR);

endmodule : i2c_slave_random_read

// File: i2c_rr_pkg.sv
// Purpose: shared constants and types for the serial memory read engine
// Assumes: one core clock; bus lines sampled, never used as clocks
// Notes:   memory address is eleven bits, data bytes are eight bits
package i2c_rr_pkg;

    localparam int         ADDR_W      = 11;
    localparam int         DATA_W      = 8;
    localparam int         CLK_NS      = 5;      // core clock period
    localparam logic [3:0] DEV_SELECT  = 4'ha;   // device-select pattern
    localparam int         ID_DEV_LSB  = 4;      // select pattern in bits 7:4
    localparam int         ID_HI_LSB   = 1;      // high address in bits 3:1
    localparam int         ID_RW_BIT   = 0;      // direction bit
    localparam int         HI_W        = 3;
    localparam logic [3:0] BITS_LAST   = 4'h8;   // bits per byte
    localparam logic [3:0] CNT_ZERO    = 4'h0;
    localparam logic [ADDR_W-1:0] WIPER_ADDR = 11'h7ff;
    localparam logic [ADDR_W-1:0] PTR_RESET  = 11'h000;
    localparam logic [ADDR_W-1:0] PTR_STEP   = 11'h001;
    localparam logic [2:0] LINE_IDLE   = 3'h7;   // released lines read high

    // conditions seen on the two bus lines, one core cycle each
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } line_event_type;

    typedef enum {ST_IDLE, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN, ST_WAIT} state_type;

    // what the byte being received or acknowledged is
    typedef enum {KIND_ID, KIND_WRITE, KIND_ADDR, KIND_READ} byte_kind_type;

endpackage : i2c_rr_pkg

// File: i2c_line_watch.sv
// Purpose: synchronise the bus lines and detect edges, start and stop
// Assumes: line clock far slower than the core clock
// Notes:   first stage of each chain is read only by the second stage
`timescale 1ns/1ps
module i2c_line_watch
    import i2c_rr_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     scl_i,
    input  wire logic     sda_i,
    output line_event_type ev_o
);

    logic [2:0] scl_pipe_reg;
    logic [2:0] scl_pipe_next;
    logic [2:0] sda_pipe_reg;
    logic [2:0] sda_pipe_next;

    // two-flop chain plus one history stage per line
    always_comb begin
        scl_pipe_next = {scl_pipe_reg[1:0], scl_i};
        sda_pipe_next = {sda_pipe_reg[1:0], sda_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_pipe_reg <= LINE_IDLE;
            sda_pipe_reg <= LINE_IDLE;
        end else begin
            scl_pipe_reg <= scl_pipe_next;
            sda_pipe_reg <= sda_pipe_next;
        end
    end

    // start and stop need clock high in both compared samples
    always_comb begin
        ev_o.scl_rise = scl_pipe_reg[1] & ~scl_pipe_reg[2];
        ev_o.scl_fall = ~scl_pipe_reg[1] & scl_pipe_reg[2];
        ev_o.start    = scl_pipe_reg[1] & scl_pipe_reg[2] & ~sda_pipe_reg[1] & sda_pipe_reg[2];
        ev_o.stop     = scl_pipe_reg[1] & scl_pipe_reg[2] & sda_pipe_reg[1] & ~sda_pipe_reg[2];
        ev_o.sda      = sda_pipe_reg[1];
    end

endmodule : i2c_line_watch

// File: i2c_master_model.sv
// Purpose: behavioural bus master that clocks the read engine
// Assumes: pull-up on SDA, so a released line reads high
// Notes:   SCL stands high between frames; period is 32 core cycles
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // quarter and half of the line clock, moved just after a core edge
    task automatic qp;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : qp

    task automatic hp;
        qp();
        qp();
    endtask : hp

    // start and repeated start alike; sda moves a quarter after scl fell
    task automatic start;
        qp();
        sda_o = 1'b1;
        qp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b0;
        hp();
        scl_o = 1'b0;
    endtask : start

    task automatic stop;
        qp();
        sda_o = 1'b0;
        qp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b1;
        hp();
    endtask : stop

    // one bit, sampled at the end of the high phase so the device has settled
    task automatic bit_io(input logic b, output logic r);
        qp();
        sda_o = b;
        qp();
        scl_o = 1'b1;
        hp();
        r = sda_i;
        scl_o = 1'b0;
    endtask : bit_io

    // byte out msb first, then release for the device's acknowledge
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask : wb

    // byte in; last high means no acknowledge, ending the stream
    task automatic rb(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : rb
endmodule : i2c_master_model

// File: i2c_slave_random_read_tb_top.sv
// Purpose: self-checking bench for the serial memory read engine
// Assumes: memory model answers combinationally from the read pointer
// Notes:   monitor rebuilds sent bytes from the bus, not from the driver
`timescale 1ns/1ps
module i2c_slave_random_read_tb_top;
    import i2c_rr_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              scl, m_sda, sda, sda_o, sda_oe_n, nv_start, read_act;
    logic              vol = 1'b0, pend = 1'b0, busy = 1'b0;
    logic [DATA_W-1:0] wiper = 8'h00, stored = 8'h00, sh;
    logic [DATA_W-1:0] mem [2048];
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] expq [$];
    logic [7:0]        nv_cnt = 8'h00;
    logic [31:0]       seed = 32'h00000039;
    int                fails = 0, checked = 0, nb = 0;

    always #2.5 clk = ~clk;
    // open-drain wire: anyone pulling low wins
    assign sda = m_sda & (sda_oe_n | sda_o);

    i2c_master_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

    i2c_slave_random_read dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda),
        .MEM_RDATA_I(mem[mem_addr]), .WIPER_POSITION_REGISTER_I(wiper),
        .STORED_WIPER_VALUE_I(stored), .VOLATILE_ONLY_SELECT_I(vol),
        .NV_WRITE_PENDING_I(pend), .NV_WRITE_BUSY_I(busy), .SDA_O(sda_o),
        .SDA_OE_N_O(sda_oe_n), .MEM_ADDR_O(mem_addr), .NV_WRITE_START_O(nv_start),
        .READ_ACTIVE_O(read_act));

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // non-volatile write launches counted per core cycle
    always @(posedge clk) begin
        if (nv_start === 1'b1) nv_cnt <= nv_cnt + 8'h01;
    end

    // monitor: eight bits per byte while sending, ninth is the master's answer
    always @(posedge scl) begin
        if (read_act !== 1'b1) nb = 0;
        else begin
            if (nb < 8) sh = {sh[6:0], sda};
            nb++;
            if (nb == 8) check(sh, (expq.size() > 0) ? expq.pop_front() : ~sh);
            if (nb == 9) nb = 0;
        end
    end

    // full random read: three instruction bytes then n data bytes
    task automatic rd(input logic [10:0] a, input int n);
        logic       ack;
        logic [7:0] d, k;
        logic [10:0] p;
        p = a;
        k = nv_cnt;
        m.start();
        m.wb({DEV_SELECT, a[10:8], 1'b0}, ack);
        check({7'h00, ack}, 8'h00);
        m.wb(a[7:0], ack);
        check({7'h00, ack}, 8'h00);
        m.start();
        m.wb({DEV_SELECT, a[10:8], 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            expq.push_back((p == WIPER_ADDR) ? (vol ? wiper : stored) : mem[p]);
            m.rb(i == n - 1, d);
            p = p + PTR_STEP; // wraps at the top of the map
        end
        // look a little after the edge so the outputs have settled
        repeat (6) @(posedge clk);
        #1;
        check({7'h00, sda_oe_n}, 8'h01);
        check({7'h00, read_act}, 8'h00);
        check({7'h00, sda_o}, 8'h00);
        check(nv_cnt, k);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        check({7'h00, read_act}, 8'h00);
        check(nv_cnt, k + {7'h00, pend});
    endtask : rd

    // a refused id: no acknowledge, then the bus is closed
    task automatic refused(input logic [7:0] id);
        logic ack;
        m.start();
        m.wb(id, ack);
        check({7'h00, ack}, 8'h01);
        m.stop();
    endtask : refused

    // read id with no address byte: streams on from the kept pointer
    task automatic cur_rd(input logic [ADDR_W-1:0] a);
        logic       ack;
        logic [7:0] d;
        m.start();
        m.wb({DEV_SELECT, a[10:8], 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        expq.push_back(mem[a]);
        m.rb(1'b1, d);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        check({7'h00, read_act}, 8'h00);
    endtask : cur_rd

    initial begin
        logic [7:0] hi, lo;
        for (int i = 0; i < 2048; i++) mem[i] = xs();
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        // random addresses and lengths
        for (int j = 0; j < 3; j++) begin
            hi = xs();
            lo = xs();
            rd({hi[2:0], lo}, 1 + (hi[7:6]));
        end
        // wrap through the wiper location with both sources
        wiper = xs();
        stored = xs();
        vol = 1'b1;
        rd(11'h7fe, 3);
        vol = 1'b0;
        pend = 1'b1;
        rd(11'h7ff, 2);
        pend = 1'b0;
        // wrong select patterns; a correct one while a write cycle runs
        for (int j = 0; j < 3; j++) begin
            hi = xs();
            if (hi[7:4] == DEV_SELECT) hi = hi ^ 8'h10;
            refused(hi);
        end
        busy = 1'b1;
        refused(8'ha0);
        busy = 1'b0;
        rd(11'h123, 1);
        // pointer was left one past the last byte sent
        cur_rd(11'h124);
        // every noted byte must have been seen on the bus
        check(8'(expq.size()), 8'h00);
        complete_run();
    end

    // hang guard, well beyond the expected run length
    initial begin
        #400us;
        fails++;
        complete_run();
    end
endmodule : i2c_slave_random_read_tb_top
